// >>> pmc_consts.svh
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PMC_CLK_HZ 10000000
`define PMC_BAUD_BPS 9600
`define PMC_BIT_CYCLES ((`PMC_CLK_HZ + `PMC_BAUD_BPS / 2) / `PMC_BAUD_BPS)
`define PMC_BLINK_MS 250
`define PMC_BLINK_CYCLES (`PMC_CLK_HZ / 1000 * `PMC_BLINK_MS)
`define PMC_LOAD_MS 20
`define PMC_LOAD_CYCLES (`PMC_CLK_HZ / 1000 * `PMC_LOAD_MS)
`define PMC_SETTLE_CYCLES 3'h4

// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define PMC_OFS_CTRL 12'h000
`define PMC_OFS_STATUS 12'h004
`define PMC_OFS_DELAY 12'h008
`define PMC_OFS_CHECK 12'h00c
`define PMC_CTRL_HOLD 0
`define PMC_ST_PERR 8
`define PMC_ST_REFUSED 9
`define PMC_ST_PROTECTED 10
`define PMC_ST_ERROR 11

// ----------------------------------------
// message codes
// ----------------------------------------
`define PMC_CMD_READ 8'h52
`define PMC_CMD_WRITE 8'h57
`define PMC_CMD_STATUS 8'h53
`define PMC_ACK_OK 8'h00
`define PMC_ACK_REFUSED 8'h01
`define PMC_PROTECT_LAST 16'h07ff

`endif

// >>> pmc_pkg.sv
package pmc_pkg;
  typedef enum logic [2:0] {
    MODE_POWERUP, MODE_CLEAR, MODE_CHECK, MODE_LOAD,
    MODE_HALT, MODE_RUN, MODE_HOLD, MODE_ERROR
  } pmc_mode_e;
endpackage : pmc_pkg

// >>> pmc_top.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_top #(
  parameter int DATA_WORDS = 16,
  parameter int PROG_WORDS = 16,
  parameter int BLINK_CYCLES = `PMC_BLINK_CYCLES,
  parameter int LOAD_CYCLES = `PMC_LOAD_CYCLES
) (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [31:0] PRDATA_OUT,
  // programmer port
  input wire logic RXD_IN,
  output logic TXD_OUT,
  output logic RTS_OUT,
  // panel switches and backup sense
  input wire logic RUN_SWITCH_IN,
  input wire logic PROTECT_RUN_SWITCH_IN,
  input wire logic ROM_RAM_SELECT_SWITCH_IN,
  input wire logic PARITY_SELECT_SWITCH_IN,
  input wire logic [1:0] COMM_SELECT_SWITCHES_IN,
  input wire logic BACKUP_LOST_IN,
  // status
  output logic RUN_LED_OUT,
  output logic PROGRAM_RUN_OUT,
  output logic [2:0] COMM_FUNCTION_SELECT_OUT
);

  localparam logic [10:0] BIT_CYCLES = 11'(`PMC_BIT_CYCLES);
  localparam logic [10:0] HALF_CYCLES = 11'(`PMC_BIT_CYCLES / 2);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] sync_q [0:6];
  logic [6:0] pin_level;
  wire [6:0] pin_raw = {BACKUP_LOST_IN, COMM_SELECT_SWITCHES_IN, PARITY_SELECT_SWITCH_IN,
                        ROM_RAM_SELECT_SWITCH_IN, PROTECT_RUN_SWITCH_IN, RXD_IN};
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_sync
      always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
      begin
        if (RST_IN)
        begin
          sync_q[gi] <= (gi == 0) ? 3'h7 : 3'h0;
          pin_level[gi] <= (gi == 0);
        end
        else
        begin
          sync_q[gi] <= {sync_q[gi][1:0], pin_raw[gi]};
          if (sync_q[gi][1] == sync_q[gi][2])
            pin_level[gi] <= sync_q[gi][2];
        end
      end
    end
  endgenerate
  logic [2:0] run_sync;
  logic run_sw;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      run_sync <= 3'h0;
      run_sw <= 1'b0;
    end
    else
    begin
      run_sync <= {run_sync[1:0], RUN_SWITCH_IN};
      if (run_sync[1] == run_sync[2])
        run_sw <= run_sync[2];
    end
  end
  wire rx_level = pin_level[0];
  wire protect_sw = pin_level[1];
  wire rom_sel = ~pin_level[2];
  wire parity_on = ~pin_level[3];
  wire [1:0] comm_sel = pin_level[5:4];
  wire backup_lost = pin_level[6];

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  pmc_pkg::pmc_mode_e mode;
  logic ctrl_hold, perr_flag, refused_flag, check_error;
  logic [15:0] resp_delay, check_code;
  logic perr_event;
  wire apb_acc = PSEL_IN & PENABLE_IN;
  wire apb_done = apb_acc & PREADY_OUT;
  wire sel_ctrl = PADDR_IN == `PMC_OFS_CTRL;
  wire sel_status = PADDR_IN == `PMC_OFS_STATUS;
  wire sel_delay = PADDR_IN == `PMC_OFS_DELAY;
  wire sel_check = PADDR_IN == `PMC_OFS_CHECK;
  wire sel_any = sel_ctrl | sel_status | sel_delay | sel_check;
  wire wr_done = apb_done & PWRITE_IN;
  wire mode_running = (mode == pmc_pkg::MODE_RUN) | (mode == pmc_pkg::MODE_HOLD);
  wire protected_run = mode_running & protect_sw;
  wire [31:0] status_word = {20'h0, check_error, protected_run, refused_flag, perr_flag,
                             5'h0, mode};
  wire [31:0] read_word = sel_ctrl ? {31'h0, ctrl_hold} :
                          sel_status ? status_word :
                          sel_delay ? {16'h0, resp_delay} :
                          sel_check ? {16'h0, check_code} : 32'h0;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= 32'h0;
    end
    else
    begin
      PREADY_OUT <= apb_acc & ~PREADY_OUT;
      PSLVERR_OUT <= apb_acc & ~PREADY_OUT & ~sel_any;
      PRDATA_OUT <= (apb_acc & ~PREADY_OUT & ~PWRITE_IN) ? read_word : 32'h0;
    end
  end
  wire hold_wr = wr_done & sel_ctrl;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      ctrl_hold <= 1'b0;
      refused_flag <= 1'b0;
      perr_flag <= 1'b0;
      resp_delay <= 16'h0;
      check_code <= 16'h0;
    end
    else
    begin
      if (hold_wr & mode_running)
        ctrl_hold <= PWDATA_IN[`PMC_CTRL_HOLD];
      else if (!mode_running)
        ctrl_hold <= 1'b0;
      if (hold_wr & ~mode_running)
        refused_flag <= 1'b1;
      else if (wr_done & sel_status & PWDATA_IN[`PMC_ST_REFUSED])
        refused_flag <= 1'b0;
      if (perr_event)
        perr_flag <= 1'b1;
      else if (wr_done & sel_status & PWDATA_IN[`PMC_ST_PERR])
        perr_flag <= 1'b0;
      if (wr_done & sel_delay)
        resp_delay <= PWDATA_IN[15:0];
      if (wr_done & sel_check)
        check_code <= PWDATA_IN[15:0];
    end
  end

  // ----------------------------------------
  // mode control
  // ----------------------------------------
  logic [31:0] mode_cnt;
  logic [15:0] check_acc;
  logic [15:0] prog_mem [0:PROG_WORDS-1];
  wire load_needed = rom_sel & ~(run_sw & protect_sw);
  wire cnt_last_data = mode_cnt == 32'(DATA_WORDS - 1);
  wire cnt_last_prog = mode_cnt == 32'(PROG_WORDS - 1);
  wire [15:0] check_next = check_acc ^ prog_mem[mode_cnt[$clog2(PROG_WORDS)-1:0]];
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      mode <= pmc_pkg::MODE_POWERUP;
      mode_cnt <= 32'h0;
      check_acc <= 16'h0;
      check_error <= 1'b0;
    end
    else
    begin
      mode_cnt <= mode_cnt + 32'h1;
      unique case (mode)
        pmc_pkg::MODE_POWERUP:
          if (mode_cnt[2:0] == `PMC_SETTLE_CYCLES)
          begin
            mode_cnt <= 32'h0;
            check_acc <= 16'h0;
            if (backup_lost)
              mode <= pmc_pkg::MODE_CLEAR;
            else if (load_needed)
              mode <= pmc_pkg::MODE_LOAD;
            else
              mode <= run_sw ? pmc_pkg::MODE_RUN : pmc_pkg::MODE_HALT;
          end
        pmc_pkg::MODE_CLEAR:
          if (cnt_last_data)
          begin
            mode <= pmc_pkg::MODE_CHECK;
            mode_cnt <= 32'h0;
          end
        pmc_pkg::MODE_CHECK:
          begin
            check_acc <= check_next;
            if (cnt_last_prog)
            begin
              mode_cnt <= 32'h0;
              check_error <= check_next != check_code;
              if (check_next != check_code)
                mode <= pmc_pkg::MODE_ERROR;
              else if (load_needed)
                mode <= pmc_pkg::MODE_LOAD;
              else
                mode <= run_sw ? pmc_pkg::MODE_RUN : pmc_pkg::MODE_HALT;
            end
          end
        pmc_pkg::MODE_LOAD:
          if (mode_cnt == 32'(LOAD_CYCLES - 1))
            mode <= run_sw ? pmc_pkg::MODE_RUN : pmc_pkg::MODE_HALT;
        pmc_pkg::MODE_HALT:
          begin
            mode_cnt <= 32'h0;
            if (run_sw)
              mode <= load_needed ? pmc_pkg::MODE_LOAD : pmc_pkg::MODE_RUN;
          end
        pmc_pkg::MODE_RUN:
          begin
            mode_cnt <= 32'h0;
            if (!run_sw)
              mode <= pmc_pkg::MODE_HALT;
            else if (ctrl_hold)
              mode <= pmc_pkg::MODE_HOLD;
          end
        pmc_pkg::MODE_HOLD:
          begin
            if (mode_cnt == 32'(BLINK_CYCLES - 1))
              mode_cnt <= 32'h0;
            if (!run_sw)
              mode <= pmc_pkg::MODE_HALT;
            else if (!ctrl_hold)
              mode <= pmc_pkg::MODE_RUN;
          end
        pmc_pkg::MODE_ERROR:
          mode_cnt <= 32'h0;
      endcase
    end
  end
  logic blink;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      blink <= 1'b0;
      RUN_LED_OUT <= 1'b0;
      PROGRAM_RUN_OUT <= 1'b0;
      COMM_FUNCTION_SELECT_OUT <= 3'h0;
      RTS_OUT <= 1'b0;
    end
    else
    begin
      if (mode == pmc_pkg::MODE_HOLD && mode_cnt == 32'(BLINK_CYCLES - 1))
        blink <= ~blink;
      RUN_LED_OUT <= (mode == pmc_pkg::MODE_RUN) | ((mode == pmc_pkg::MODE_HOLD) & blink);
      PROGRAM_RUN_OUT <= mode == pmc_pkg::MODE_RUN;
      // one-hot: computer link, data link, serial interface; none when reserved
      COMM_FUNCTION_SELECT_OUT <= {comm_sel == 2'h2, comm_sel == 2'h1, comm_sel == 2'h0};
      RTS_OUT <= 1'b1;
    end
  end

  // ----------------------------------------
  // serial receiver
  // ----------------------------------------
  logic rx_active, byte_valid, byte_perr, rx_par;
  logic [10:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] rx_data, rx_byte;
  wire [3:0] rx_last = parity_on ? 4'ha : 4'h9;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      rx_active <= 1'b0;
      rx_cnt <= 11'h0;
      rx_bit <= 4'h0;
      rx_data <= 8'h0;
      rx_par <= 1'b0;
      rx_byte <= 8'h0;
      byte_valid <= 1'b0;
      byte_perr <= 1'b0;
    end
    else
    begin
      byte_valid <= 1'b0;
      if (!rx_active)
      begin
        rx_active <= ~rx_level;
        rx_cnt <= HALF_CYCLES;
        rx_bit <= 4'h0;
      end
      else if (rx_cnt != 11'h0)
        rx_cnt <= rx_cnt - 11'h1;
      else
      begin
        rx_cnt <= BIT_CYCLES - 11'h1;
        rx_bit <= rx_bit + 4'h1;
        if (rx_bit == 4'h0 && rx_level)
          rx_active <= 1'b0;
        else if (rx_bit >= 4'h1 && rx_bit <= 4'h8)
          rx_data <= {rx_level, rx_data[7:1]};
        else if (rx_bit == 4'h9 && parity_on)
          rx_par <= rx_level;
        if (rx_bit == rx_last)
        begin
          rx_active <= 1'b0;
          byte_valid <= 1'b1;
          rx_byte <= rx_data;
          byte_perr <= ~rx_level | (parity_on & ~(^{rx_data, rx_par}));
        end
      end
    end
  end
  assign perr_event = byte_valid & byte_perr;

  // ----------------------------------------
  // message parser and execution
  // ----------------------------------------
  logic [2:0] msg_idx;
  logic [7:0] msg_cmd;
  logic [15:0] msg_addr, msg_data;
  logic msg_bad, exec;
  logic [15:0] data_mem [0:DATA_WORDS-1];
  wire cmd_ok = (rx_byte == `PMC_CMD_READ) | (rx_byte == `PMC_CMD_WRITE) |
                (rx_byte == `PMC_CMD_STATUS);
  wire [2:0] msg_len = (msg_cmd == `PMC_CMD_WRITE) ? 3'h5 : 3'h3;
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      msg_idx <= 3'h0;
      msg_cmd <= 8'h0;
      msg_addr <= 16'h0;
      msg_data <= 16'h0;
      msg_bad <= 1'b0;
      exec <= 1'b0;
    end
    else
    begin
      exec <= 1'b0;
      if (byte_valid && msg_idx == 3'h0 && cmd_ok)
      begin
        msg_cmd <= rx_byte;
        msg_bad <= byte_perr;
        msg_idx <= (rx_byte == `PMC_CMD_STATUS) ? 3'h0 : 3'h1;
        exec <= (rx_byte == `PMC_CMD_STATUS) & ~byte_perr;
      end
      else if (byte_valid && msg_idx != 3'h0)
      begin
        msg_bad <= msg_bad | byte_perr;
        if (msg_idx > 3'h2)
          msg_data <= {msg_data[7:0], rx_byte};
        else
          msg_addr <= {msg_addr[7:0], rx_byte};
        msg_idx <= (msg_idx == msg_len - 3'h1) ? 3'h0 : msg_idx + 3'h1;
        exec <= (msg_idx == msg_len - 3'h1) & ~msg_bad & ~byte_perr;
      end
    end
  end
  wire prog_area = msg_addr[15];
  wire addr_in_data = ~prog_area & (msg_addr < 16'(DATA_WORDS));
  wire addr_in_prog = prog_area & (msg_addr[14:0] < 15'(PROG_WORDS));
  wire write_locked = protected_run & (prog_area | (msg_addr <= `PMC_PROTECT_LAST));
  wire write_ok = ~write_locked & (addr_in_data | addr_in_prog);
  wire do_write = exec & (msg_cmd == `PMC_CMD_WRITE) & write_ok;
  wire [15:0] rd_word = addr_in_prog ? prog_mem[msg_addr[$clog2(PROG_WORDS)-1:0]] :
                        addr_in_data ? data_mem[msg_addr[$clog2(DATA_WORDS)-1:0]] : 16'h0;
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (mode == pmc_pkg::MODE_CLEAR)
      data_mem[mode_cnt[$clog2(DATA_WORDS)-1:0]] <= 16'h0;
    else if (do_write & addr_in_data)
      data_mem[msg_addr[$clog2(DATA_WORDS)-1:0]] <= msg_data;
  end
  // program image starts cleared so its check code is never unknown
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      for (int i = 0; i < PROG_WORDS; i++)
        prog_mem[i] <= 16'h0;
    end
    else if (do_write & addr_in_prog)
      prog_mem[msg_addr[$clog2(PROG_WORDS)-1:0]] <= msg_data;
  end

  // ----------------------------------------
  // response delay and transmitter
  // ----------------------------------------
  logic [7:0] resp [0:2];
  logic [1:0] resp_left, resp_sel;
  logic [15:0] wait_bits;
  logic [10:0] tx_cnt;
  logic [3:0] tx_left;
  logic [10:0] tx_shift;
  wire tx_idle = tx_left == 4'h0;
  wire bit_tick = tx_cnt == 11'h0;
  wire [7:0] tx_byte = resp[resp_sel];
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      resp[0] <= 8'h0;
      resp[1] <= 8'h0;
      resp[2] <= 8'h0;
      resp_left <= 2'h0;
      resp_sel <= 2'h0;
      wait_bits <= 16'h0;
      tx_cnt <= 11'h0;
      tx_left <= 4'h0;
      tx_shift <= 11'h7ff;
      TXD_OUT <= 1'b1;
    end
    else
    begin
      tx_cnt <= bit_tick ? BIT_CYCLES - 11'h1 : tx_cnt - 11'h1;
      if (exec && resp_left == 2'h0)
      begin
        resp[0] <= msg_cmd;
        resp[1] <= (msg_cmd == `PMC_CMD_READ) ? rd_word[15:8] :
                   (msg_cmd == `PMC_CMD_WRITE) ?
                   (write_ok ? `PMC_ACK_OK : `PMC_ACK_REFUSED) : status_word[7:0];
        resp[2] <= (msg_cmd == `PMC_CMD_READ) ? rd_word[7:0] : status_word[15:8];
        resp_left <= (msg_cmd == `PMC_CMD_WRITE) ? 2'h2 : 2'h3;
        resp_sel <= 2'h0;
        wait_bits <= resp_delay;
      end
      else if (wait_bits != 16'h0)
      begin
        if (bit_tick)
          wait_bits <= wait_bits - 16'h1;
      end
      else if (tx_idle && resp_left != 2'h0 && bit_tick)
      begin
        tx_shift <= parity_on ? {1'b1, ~(^tx_byte), tx_byte, 1'b0} :
                                {2'h3, tx_byte, 1'b0};
        tx_left <= parity_on ? 4'hb : 4'ha;
        resp_left <= resp_left - 2'h1;
        resp_sel <= resp_sel + 2'h1;
      end
      if (!tx_idle && bit_tick)
      begin
        TXD_OUT <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_left <= tx_left - 4'h1;
      end
    end
  end

endmodule : pmc_top
`default_nettype wire

// >>> pmc_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_top_monitor #(
  parameter int BLINK_CYCLES = `PMC_BLINK_CYCLES
) (
  // clock and reset
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  // apb
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic [31:0] PRDATA_OUT,
  // serial and panel
  input wire logic TXD_OUT,
  input wire logic RUN_SWITCH_IN,
  input wire logic PARITY_SELECT_SWITCH_IN,
  input wire logic [1:0] COMM_SELECT_SWITCHES_IN,
  input wire logic RUN_LED_OUT,
  input wire logic PROGRAM_RUN_OUT,
  input wire logic [2:0] COMM_FUNCTION_SELECT_OUT
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  localparam int LOW_ODD = 10 * `PMC_BIT_CYCLES;
  localparam int LOW_NONE = 9 * `PMC_BIT_CYCLES;
  logic [15:0] low_cnt;
  logic [31:0] lit_cnt;
  wire logic [2:0] comm_exp;
  assign comm_exp = (COMM_SELECT_SWITCHES_IN == 2'h3) ? 3'h0 : 3'h1 << COMM_SELECT_SWITCHES_IN;

  // length of the current low run on the transmit line
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN) low_cnt <= 16'h0;
    else if (TXD_OUT) low_cnt <= 16'h0;
    else low_cnt <= low_cnt + 16'h1;
  end

  // cycles the run lamp stays lit while the program is not running
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN)
  begin
    if (RST_IN) lit_cnt <= 32'h0;
    else if (RUN_LED_OUT && !PROGRAM_RUN_OUT) lit_cnt <= lit_cnt + 32'h1;
    else lit_cnt <= 32'h0;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);

  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence

  property p_apb_answer;
    s_setup ##1 s_access |=> PREADY_OUT;
  endproperty
  property p_ready_pulse;
    PREADY_OUT |-> PSEL_IN && PENABLE_IN ##1 !PREADY_OUT;
  endproperty
  property p_err_with_ready;
    PSLVERR_OUT |-> PREADY_OUT;
  endproperty
  property p_rdata_idle;
    !PREADY_OUT |-> PRDATA_OUT == 32'h0;
  endproperty
  property p_frame_low;
    low_cnt <= (PARITY_SELECT_SWITCH_IN ? LOW_NONE : LOW_ODD);
  endproperty
  property p_comm_onehot;
    $onehot0(COMM_FUNCTION_SELECT_OUT);
  endproperty
  property p_comm_map;
    $stable(COMM_SELECT_SWITCHES_IN) [*8] |-> COMM_FUNCTION_SELECT_OUT == comm_exp;
  endproperty
  property p_led_in_run;
    PROGRAM_RUN_OUT && $past(PROGRAM_RUN_OUT) |-> RUN_LED_OUT;
  endproperty
  property p_led_blink;
    lit_cnt <= 32'(BLINK_CYCLES);
  endproperty
  property p_halt_stops;
    !RUN_SWITCH_IN [*8] |=> !PROGRAM_RUN_OUT;
  endproperty

  a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready outside access");
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  a_frame_low: assert property (p_frame_low) else $error("frame too long");
  a_comm_onehot: assert property (p_comm_onehot) else $error("function not one-hot");
  a_comm_map: assert property (p_comm_map) else $error("function decode wrong");
  a_led_in_run: assert property (p_led_in_run) else $error("led off in run");
  a_led_blink: assert property (p_led_blink) else $error("led stuck in hold");
  a_halt_stops: assert property (p_halt_stops) else $error("program runs in halt");
endmodule : pmc_top_monitor

bind pmc_top pmc_top_monitor #(.BLINK_CYCLES(BLINK_CYCLES)) pmc_top_monitor_inst (
  .CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .PRDATA_OUT(PRDATA_OUT),
  .TXD_OUT(TXD_OUT), .RUN_SWITCH_IN(RUN_SWITCH_IN),
  .PARITY_SELECT_SWITCH_IN(PARITY_SELECT_SWITCH_IN),
  .COMM_SELECT_SWITCHES_IN(COMM_SELECT_SWITCHES_IN), .RUN_LED_OUT(RUN_LED_OUT),
  .PROGRAM_RUN_OUT(PROGRAM_RUN_OUT), .COMM_FUNCTION_SELECT_OUT(COMM_FUNCTION_SELECT_OUT)
);
`default_nettype wire

// >>> pmc_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module pmc_host_model #(
  parameter int BIT = 1042
) (
  // clock and setting
  input wire logic clk_in,
  input wire logic parity_off_in,
  // serial lines, no handshake lines used
  input wire logic txd_in,
  output logic rxd_out
);
  initial rxd_out = 1'b1;

  // ----------------------------------------
  // one character to the device
  // ----------------------------------------
  task automatic send_byte(input logic [7:0] d, input logic bad);
    logic [10:0] f;
    f = {1'b1, ~^d ^ bad, d, 1'b0};
    if (parity_off_in) f[9] = 1'b1;
    for (int i = 0; i < (parity_off_in ? 10 : 11); i++)
    begin
      @(posedge clk_in);
      rxd_out <= f[i];
      repeat (BIT - 1) @(posedge clk_in);
    end
  endtask : send_byte

  // ----------------------------------------
  // one character from the device, ends mid stop bit
  // ----------------------------------------
  task automatic recv_byte(output logic [7:0] d, output logic ok);
    logic [10:0] b;
    int n;
    n = parity_off_in ? 10 : 11;
    b = 11'h0;
    @(posedge clk_in);
    while (txd_in !== 1'b0) @(posedge clk_in);
    repeat (BIT / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      b[i] = txd_in;
      if (i < n - 1) repeat (BIT) @(posedge clk_in);
    end
    d = b[8:1];
    ok = !b[0] && b[n - 1] && (parity_off_in || ^b[9:1]);
  endtask : recv_byte
endmodule : pmc_host_model
`default_nettype wire

// >>> pmc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmc_consts.svh"

module pmc_top_bench;
  localparam int BIT = `PMC_BIT_CYCLES;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic rxd;
  logic txd;
  logic rts;
  logic run_sw = 1'b1;
  logic protect_sw = 1'b0;
  logic rom_ram_sw = 1'b0;
  logic parity_sw = 1'b0;
  logic [1:0] comm_sw = 2'h0;
  logic backup_lost = 1'b0;
  logic run_led;
  logic program_run;
  logic [2:0] comm_out;
  logic [31:0] rdata;
  logic perr;
  logic seen;
  logic [7:0] rb [3];
  logic rok [3];
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  int tx_falls = 0;
  int f0;

  always #50 clk_sys = ~clk_sys;
  always @(negedge txd) tx_falls++;

  pmc_top #(.BLINK_CYCLES(8), .LOAD_CYCLES(16)) pmc_top_inst (
    .CLK_SYS_IN(clk_sys), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .PRDATA_OUT(prdata), .RXD_IN(rxd), .TXD_OUT(txd), .RTS_OUT(rts),
    .RUN_SWITCH_IN(run_sw), .PROTECT_RUN_SWITCH_IN(protect_sw),
    .ROM_RAM_SELECT_SWITCH_IN(rom_ram_sw), .PARITY_SELECT_SWITCH_IN(parity_sw),
    .COMM_SELECT_SWITCHES_IN(comm_sw), .BACKUP_LOST_IN(backup_lost), .RUN_LED_OUT(run_led),
    .PROGRAM_RUN_OUT(program_run), .COMM_FUNCTION_SELECT_OUT(comm_out)
  );
  pmc_host_model #(.BIT(BIT)) pmc_host_model_inst (
    .clk_in(clk_sys), .parity_off_in(parity_sw), .txd_in(txd), .rxd_out(rxd)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdata = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask : rd_chk

  // poll mode, noting whether a given mode passed by
  task wait_mode(input logic [2:0] m, input logic [2:0] look, output logic hit);
    hit = 1'b0;
    do
    begin
      apb(1'b0, `PMC_OFS_STATUS, 32'h0);
      if (rdata[2:0] === look) hit = 1'b1;
    end while (rdata[2:0] !== m);
  endtask : wait_mode

  task do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
  endtask : do_reset

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      fails++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    do_reset();
    wait_mode(3'h5, 3'h3, seen);
    check(seen, 1'b1);
    check(program_run, 1'b1);
    check(rts, 1'b1);
    fork
      pmc_host_model_inst.send_byte(`PMC_CMD_STATUS, 1'b0);
      for (int k = 0; k < 3; k++) pmc_host_model_inst.recv_byte(rb[k], rok[k]);
    join
    check(rb[0], `PMC_CMD_STATUS);
    check(rb[1], 8'h05);
    check(rb[2], 8'h00);
    check({rok[0], rok[1], rok[2]}, 3'h7);
    f0 = tx_falls;
    pmc_host_model_inst.send_byte(`PMC_CMD_STATUS, 1'b1);
    repeat (3 * BIT) @(posedge clk_sys);
    check(tx_falls, f0);
    rd_chk(`PMC_OFS_STATUS, 32'h105);
    apb(1'b1, `PMC_OFS_STATUS, 32'h100);
    rd_chk(`PMC_OFS_STATUS, 32'h005);
    apb(1'b0, 12'h010, 32'h0);
    check(perr, 1'b1);
    check(rdata, 32'h0);
    apb(1'b1, `PMC_OFS_DELAY, 32'h3);
    rd_chk(`PMC_OFS_DELAY, 32'h3);
    apb(1'b1, `PMC_OFS_CHECK, 32'h1234);
    rd_chk(`PMC_OFS_CHECK, 32'h1234);
    apb(1'b1, `PMC_OFS_CTRL, 32'h1);
    wait_mode(3'h6, 3'h6, seen);
    check(program_run, 1'b0);
    repeat (20) @(posedge clk_sys);
    apb(1'b1, `PMC_OFS_CTRL, 32'h0);
    wait_mode(3'h5, 3'h5, seen);
    // halt refuses mode requests
    @(posedge clk_sys);
    run_sw <= 1'b0;
    wait_mode(3'h4, 3'h4, seen);
    check(run_led, 1'b0);
    apb(1'b1, `PMC_OFS_CTRL, 32'h1);
    rd_chk(`PMC_OFS_STATUS, 32'h204);
    apb(1'b1, `PMC_OFS_STATUS, 32'h200);
    rd_chk(`PMC_OFS_STATUS, 32'h004);
    // protected run skips the load
    @(posedge clk_sys);
    protect_sw <= 1'b1;
    run_sw <= 1'b1;
    wait_mode(3'h5, 3'h3, seen);
    check(seen, 1'b0);
    rd_chk(`PMC_OFS_STATUS, 32'h405);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      comm_sw <= 2'(i);
      repeat (8) @(posedge clk_sys);
      check(comm_out, (i == 3) ? 3'h0 : 3'h1 << i);
    end
    // working memory start, then a plain frame answered after the delay
    @(posedge clk_sys);
    protect_sw <= 1'b0;
    rom_ram_sw <= 1'b1;
    parity_sw <= 1'b1;
    run_sw <= 1'b0;
    wait_mode(3'h4, 3'h4, seen);
    run_sw <= 1'b1;
    wait_mode(3'h5, 3'h3, seen);
    check(seen, 1'b0);
    f0 = tx_falls;
    pmc_host_model_inst.send_byte(`PMC_CMD_STATUS, 1'b0);
    repeat (3 * BIT) @(posedge clk_sys);
    check(tx_falls, f0);
    pmc_host_model_inst.recv_byte(rb[0], rok[0]);
    check(rb[0], `PMC_CMD_STATUS);
    check(rok[0], 1'b1);
    // backup lost with a wrong check code
    @(posedge clk_sys);
    backup_lost <= 1'b1;
    do_reset();
    apb(1'b1, `PMC_OFS_CHECK, 32'hbeef);
    wait_mode(3'h7, 3'h1, seen);
    check(seen, 1'b1);
    rd_chk(`PMC_OFS_STATUS, 32'h807);
    check(run_led, 1'b0);
    give_verdict();
  end
endmodule : pmc_top_bench
`default_nettype wire
